// >>> src/gped_map.vh
`ifndef GPED_MAP_VH
`define GPED_MAP_VH
`define GPED_PIN_ENABLE_OFS 32'h01B00000
`define GPED_PIN_DIRECTION_OFS 32'h01B00004
`define GPED_PIN_ENABLE_RST 16'h00F0
`define GPED_PIN_DIRECTION_RST 16'h0000
`define GPED_PINS 16
`define GPED_RSVD_LSB 16
`define GPED_WAIT_CYCLES 1
`endif

// >>> src/gped_reg16.v
`include "gped_map.vh"
module gped_reg16 #(
  parameter WIDTH = 16,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire mclk_i,
  input wire rst_i,
  input wire wr_i,
  input wire [WIDTH-1:0] wdata_i,
  output reg [WIDTH-1:0] q_o
);
  always @(posedge mclk_i) begin
    if (rst_i) begin
      q_o <= RST_VAL;
    end else if (wr_i) begin
      q_o <= wdata_i;
    end
  end
endmodule

// >>> src/gped_pin_ctrl.v
module gped_pin_ctrl #(
  parameter WIDTH = 16
) (
  input wire mclk_i,
  input wire rst_i,
  input wire [WIDTH-1:0] enable_i,
  input wire [WIDTH-1:0] direction_i,
  output reg [WIDTH-1:0] pin_oe_o,
  output reg [WIDTH-1:0] pin_in_use_o
);
  // Direction counts only on enabled pins
  always @(posedge mclk_i) begin
    if (rst_i) begin
      pin_oe_o <= {WIDTH{1'b0}};
      pin_in_use_o <= {WIDTH{1'b0}};
    end else begin
      pin_oe_o <= enable_i & direction_i;
      pin_in_use_o <= enable_i & ~direction_i;
    end
  end
endmodule

// >>> src/gped_top.v
// Behaviour
// - Sixteen pins, bit position equals pin number
// - Pin is general-purpose only when enabled
// - Direction 0 input, 1 output driving pin
// - Direction ignored while pin disabled
// - Enable resets to 0x00F0, read/write
// - Direction resets to zero, read/write
`include "gped_map.vh"
module gped_top #(
  parameter PINS = `GPED_PINS
) (
  input wire mclk_i,
  input wire rst_i,
  input wire [31:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  output wire [PINS-1:0] pin_enable_o,
  output wire [PINS-1:0] pin_direction_o,
  output wire [PINS-1:0] pin_oe_o,
  output wire [PINS-1:0] pin_input_mode_o
);
  wire [PINS-1:0] en_q;
  wire [PINS-1:0] dir_q;
  wire hit_en;
  wire hit_dir;
  wire req;
  wire take;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg wait_nxt;
  reg [31:0] rdata_nxt;

  // One-hot bus states; answer always one cycle after the request is seen
  localparam [1:0] ST_IDLE = 2'h1;
  localparam [1:0] ST_ANSWER = 2'h2;
  wire [PINS-1:0] en_wdata;
  wire [PINS-1:0] dir_wdata;

  // Byte-lane merge keeps unselected bytes of the stored value
  function [PINS-1:0] lane_merge;
    input [PINS-1:0] old_v;
    input [31:0] new_v;
    input [3:0] be;
    integer i;
    begin
      lane_merge = old_v;
      for (i = 0; i < PINS; i = i + 1) begin
        if (be[i / 8]) begin
          lane_merge[i] = new_v[i];
        end
      end
    end
  endfunction

  // Full-word compare, so aliases of the two offsets stay unmapped
  function reg_hit;
    input [31:0] addr;
    input [31:0] ofs;
    begin
      reg_hit = (addr == ofs);
    end
  endfunction

  // Upper bits left at zero, whatever the pin count
  function [31:0] read_word;
    input sel_en;
    input sel_dir;
    input [PINS-1:0] en_v;
    input [PINS-1:0] dir_v;
    begin
      read_word = 32'h00000000;
      if (sel_en) begin
        read_word[PINS-1:0] = en_v;
      end else if (sel_dir) begin
        read_word[PINS-1:0] = dir_v;
      end
    end
  endfunction

  assign hit_en = reg_hit(avs_address_i, `GPED_PIN_ENABLE_OFS);
  assign hit_dir = reg_hit(avs_address_i, `GPED_PIN_DIRECTION_OFS);
  assign req = avs_read_i | avs_write_i;
  // One wait cycle, then answer; keeps readdata registered
  assign take = req & (state_r == ST_ANSWER);
  assign en_wdata = lane_merge(en_q, avs_writedata_i, avs_byteenable_i);
  assign dir_wdata = lane_merge(dir_q, avs_writedata_i, avs_byteenable_i);

  gped_reg16 #(
    .WIDTH(PINS),
    .RST_VAL(`GPED_PIN_ENABLE_RST)
  ) u_enable (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .wr_i(take & avs_write_i & hit_en),
    .wdata_i(en_wdata),
    .q_o(en_q)
  );

  gped_reg16 #(
    .WIDTH(PINS),
    .RST_VAL(`GPED_PIN_DIRECTION_RST)
  ) u_direction (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .wr_i(take & avs_write_i & hit_dir),
    .wdata_i(dir_wdata),
    .q_o(dir_q)
  );

  gped_pin_ctrl #(
    .WIDTH(PINS)
  ) u_pins (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .enable_i(en_q),
    .direction_i(dir_q),
    .pin_oe_o(pin_oe_o),
    .pin_in_use_o(pin_input_mode_o)
  );

  assign pin_enable_o = en_q;
  assign pin_direction_o = dir_q;

  always @* begin
    state_nxt = state_r;
    wait_nxt = 1'b1;
    rdata_nxt = avs_readdata_o;
    case (state_r)
      ST_IDLE: begin
        if (req) begin
          state_nxt = ST_ANSWER;
          wait_nxt = 1'b0;
          if (avs_read_i) begin
            rdata_nxt = read_word(hit_en, hit_dir, en_q, dir_q);
          end
        end
      end
      ST_ANSWER: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h00000000;
    end else begin
      state_r <= state_nxt;
      avs_waitrequest_o <= wait_nxt;
      avs_readdata_o <= rdata_nxt;
    end
  end
endmodule

// >>> tb/gped_brd.sv
module gped_brd(input wire [15:0] oe_i,output wire [15:0] pad_o);
  timeunit 1ns; timeprecision 1ps;
  // Board pull-ups; enabled outputs drive low
  assign pad_o=~oe_i;
endmodule

// >>> tb/gped_chk.sv
`include "gped_map.vh"
module gped_chk(input wire mclk_i,rst_i,avs_read_i,avs_write_i,avs_waitrequest_o,
  input wire [3:0] avs_byteenable_i,
  input wire [31:0] avs_address_i,avs_writedata_i,avs_readdata_o,
  input wire [15:0] pin_enable_o,pin_direction_o,pin_oe_o,pin_input_mode_o);
  timeunit 1ns; timeprecision 1ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_oe;
    !$past(rst_i) |-> pin_oe_o==($past(pin_enable_o)&$past(pin_direction_o)); endproperty
  a_oe: assert property(p_oe) else $error("oe");
  property p_im;
    !$past(rst_i) |-> pin_input_mode_o==($past(pin_enable_o)&~$past(pin_direction_o)); endproperty
  a_im: assert property(p_im) else $error("input mode");
  property p_wr; !avs_waitrequest_o&&avs_write_i&&avs_byteenable_i==4'hF&&
    avs_address_i==`GPED_PIN_ENABLE_OFS |=> pin_enable_o==$past(avs_writedata_i[15:0]); endproperty
  a_wr: assert property(p_wr) else $error("enable write");
  property p_rst; $past(rst_i) |-> pin_enable_o==16'h00F0&&pin_direction_o==16'h0000; endproperty
  a_rst: assert property(p_rst) else $error("reset value");
  property p_dwr; !avs_waitrequest_o&&avs_write_i&&avs_byteenable_i==4'hF&&
    avs_address_i==`GPED_PIN_DIRECTION_OFS |=> pin_direction_o==$past(avs_writedata_i[15:0]);
  endproperty
  a_dwr: assert property(p_dwr) else $error("direction write");
  property p_rsv; !avs_waitrequest_o&&avs_read_i |-> avs_readdata_o[31:16]==16'h0000;
  endproperty
  a_rsv: assert property(p_rsv) else $error("reserved bits");
  property p_keep; !(!avs_waitrequest_o&&avs_write_i) |=>
    $stable(pin_enable_o)&&$stable(pin_direction_o); endproperty
  a_keep: assert property(p_keep) else $error("register changed without write");
  c_rd: cover property(!avs_waitrequest_o&&avs_read_i);
  c_wr: cover property(!avs_waitrequest_o&&avs_write_i);
  c_oe: cover property(|pin_oe_o);
  c_im: cover property(|pin_input_mode_o);
endmodule
bind gped_top gped_chk gped_chk_inst(.*);

// >>> tb/gped_top_tb.sv
`include "gped_map.vh"
module gped_top_tb;
  timeunit 1ns; timeprecision 1ps;
  localparam logic [31:0] EN=`GPED_PIN_ENABLE_OFS,DR=`GPED_PIN_DIRECTION_OFS;
  logic mclk_i=0,rst_i=1,rd=0,wr=0;
  logic [31:0] ad=0,wd=0,rdat,q;
  logic [3:0] be=4'hF;
  wire wt;
  wire [15:0] en,dr,oe,im,pad;
  int mismatches=0,num_checks=0,cyc=0;
  always #2 mclk_i=~mclk_i;
  gped_top gped_top_inst(.mclk_i,.rst_i,.avs_address_i(ad),.avs_read_i(rd),.avs_write_i(wr),
    .avs_writedata_i(wd),.avs_byteenable_i(be),.avs_readdata_o(rdat),.avs_waitrequest_o(wt),
    .pin_enable_o(en),.pin_direction_o(dr),.pin_oe_o(oe),.pin_input_mode_o(im));
  gped_brd gped_brd_inst(.oe_i(oe),.pad_o(pad));
  task close_out;
    $display("checks %0d mismatches %0d",num_checks,mismatches);
    if (mismatches==0&&num_checks>0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] g,e);
    num_checks++;
    if (g!==e) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h",$time,g,e);
    end
  endtask
  // Pin view: output enables, input modes, pads
  task chk_pins(input logic [47:0] g,e);
    num_checks++;
    if (g!==e) begin
      mismatches++;
      $display("MISMATCH t=%0t pins %h exp %h",$time,g,e);
    end
  endtask
  // Request held until waitrequest sampled low
  task bus(input logic w,input logic [31:0] a,d,input logic [3:0] b=4'hF);
    @(posedge mclk_i);
    rd<=!w; wr<=w; ad<=a; wd<=d; be<=b;
    do @(posedge mclk_i); while (wt!==1'b0);
    q=rdat;
    rd<=0; wr<=0;
  endtask
  task t_rst;
    bus(0,EN,0); chk(q,32'h00F0);
    bus(0,DR,0); chk(q,0);
    $display("reset test done");
  endtask
  task t_out;
    bus(1,EN,32'hFFFFFFFF); bus(1,DR,32'hA5A500FF);
    bus(0,EN,0); chk(q,32'hFFFF);
    bus(0,DR,0); chk(q,32'h00FF);
    chk_pins({oe,im,pad},48'h00FF_FF00_FF00);
    $display("output test done");
  endtask
  task t_dis;
    bus(1,EN,32'h0F0F); bus(0,EN+8,0); chk(q,0);
    chk_pins({oe,im,pad},48'h000F_0F00_FFF0);
    $display("disable test done");
  endtask
  task t_lane;
    bus(1,EN,32'h0000A500,4'h2); bus(0,EN,0); chk(q,32'hA50F);
    bus(1,DR,32'hFFFFFFFF,4'hC); bus(0,DR,0); chk(q,32'h00FF);
    $display("lane test done");
  endtask
  task t_mid;
    rst_i<=1;
    repeat (3) @(posedge mclk_i);
    rst_i<=0;
    bus(0,EN,0); chk(q,32'h00F0);
    bus(0,DR,0); chk(q,0);
    chk_pins({oe,im,pad},48'h0000_00F0_FFFF);
    $display("mid-run reset test done");
  endtask
  always @(posedge mclk_i) if (++cyc>500) begin
    mismatches++;
    close_out;
  end
  initial begin
    repeat (5) @(posedge mclk_i);
    rst_i<=0;
    t_rst; t_out; t_dis; t_lane; t_mid;
    close_out;
  end
endmodule
